// ---- seep_port.sv ----
// Decided for this implementation: the register addresses and the plain strobed port.
`include "seep_defs.svh"

// Behaviour
// RULE1 - port bit 0 drives the eeprom chip select directly
// RULE2 - port bit 2 drives eeprom serial clock only while bit 4 set
// RULE3 - port bit 3 drives eeprom write line only while bit 4 set
// RULE4 - bit 4 makes sync and video-select pins outputs carrying data and clock
// RULE5 - bit 5 freezes internal sync and video-select input states
// RULE6 - bit 1 enables the data return path from the eeprom
// RULE7 - eeprom output appears on read-only bit 7, msb first
// RULE8 - bit 6 is preserved by software on every write
// RULE9 - port works only when strapped for isa bus
// RULE10 - software sets data, raises clock, lowers clock per bit
// RULE11 - write enable pattern 0100 1100000 precedes any write
// RULE12 - write is 0101, six address bits, sixteen data bits, msb first
// RULE13 - disable programming pattern 0100 0000000 in own frame
// RULE14 - read starts with 010 and six address bits; the testbench sends 0110 (idle zero, start bit, opcode 10) before the address
// RULE15 - read then gives sixteen clock pulses, one bit captured each
// RULE16 - chip select framed around each command
// RULE17 - 64 words of sixteen bits, every transfer whole word
// RULE18 - wait at least 10 us after a write before next operation
// RULE19 - unlock with 12h, then set latch and both enables
// RULE20 - latch and enable bits held constant while in use
// RULE21 - leave: clear enables, clear latch, relock with zero
// RULE22 - clearing bit 4 releases both pins to normal input use
module seep_port
    import seep_pkg::*;
(
    input  wire logic                    clock_i,      // 250 MHz system clock
    input  wire logic                    rst_n_i,      // sync reset, active low
    input  wire logic                    isa_strap_i,  // high when strapped for isa
    input  wire logic [`SEEP_ADDR_W-1:0] addr_i,       // register index
    input  wire logic [7:0]              wdata_i,      // write data
    input  wire logic                    wr_i,         // write strobe
    input  wire logic                    rd_i,         // read strobe
    output logic      [7:0]              rdata_o,      // read data, cycle after rd_i
    input  wire seep_pins_s              pins_i,       // pad levels of sync/video pins
    output seep_pins_s                   pins_o,       // pad drive values
    output seep_pins_s                   pins_oe_n_o,  // pad enables, low drives
    input  wire logic                    eeprom_do_i,  // serial output of eeprom
    output logic                         eeprom_cs_o,  // eeprom chip select
    output seep_pins_s                   pins_state_o, // internal sync/video state
    output logic                         no_mcs16_o    // memory 16-bit cycle suppress
);
    logic [7:0] port_q, port_d;
    logic [7:0] unlock_q, unlock_d;
    logic [7:0] rdata_q, rdata_d;
    logic       isa_q, isa_d;
    logic       cs_q, cs_d;
    seep_pins_s pins_q, pins_d, oe_n_q, oe_n_d, state_q, state_d;
    seep_pins_s pins_s;
    logic       do_s;
    logic       isa_s;
    logic [3:0] sync_s;
    logic       unlocked, enabled, pin_en, bit_in;

    // strap, pins and eeprom output all come from outside the clock domain
    seep_sync #(.W(4)) u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .d_i     ({isa_strap_i, pins_i.sync, pins_i.video, eeprom_do_i}),
        .q_o     (sync_s)
    );

    // split the synchronised levels back into their roles
    assign isa_s  = sync_s[3];
    assign pins_s = sync_s[2:1];
    assign do_s   = sync_s[0];

    assign unlocked = (unlock_q == `SEEP_UNLOCK_KEY);
    assign enabled  = isa_q;                                    // [RULE9]
    assign pin_en   = enabled && port_q[`SEEP_BIT_PINEN];
    // return path gated by bit 1 so a floating line reads zero
    assign bit_in   = port_q[`SEEP_BIT_RDEN] && do_s;           // [RULE6]

    // register file and pin logic next state
    always_comb begin
        port_d   = port_q;
        unlock_d = unlock_q;
        isa_d    = isa_s;         // strap is static; a change lands three cycles later
        rdata_d  = 8'h00;
        if (wr_i && addr_i == `SEEP_ADDR_UNLOCK) begin
            unlock_d = wdata_i;
        end
        // port writes only take effect while extensions are unlocked
        if (wr_i && addr_i == `SEEP_ADDR_PORT && unlocked) begin
            port_d = {1'b0, wdata_i[6:0]};
        end
        if (rd_i) begin
            case (addr_i)
                `SEEP_ADDR_PORT:   rdata_d = {enabled && bit_in, port_q[6:0]}; // [RULE7]
                `SEEP_ADDR_UNLOCK: rdata_d = unlock_q;
                `SEEP_ADDR_STATUS: rdata_d = {6'h00, pins_s.sync, pins_s.video};
                default:           rdata_d = 8'h00;
            endcase
        end
        // chip select follows bit 0 only on an isa-strapped part
        cs_d = enabled && port_q[`SEEP_BIT_CS];                 // [RULE1]
        // borrowed pins: sync carries data, video-select carries clock
        pins_d.sync  = pin_en && port_q[`SEEP_BIT_WDATA];       // [RULE3]
        pins_d.video = pin_en && port_q[`SEEP_BIT_CLK];         // [RULE2]
        oe_n_d.sync  = !pin_en;                                 // [RULE4] [RULE22]
        oe_n_d.video = !pin_en;                                 // [RULE4] [RULE22]
        // latched inputs keep their value while pins are borrowed
        state_d = state_q;
        if (!(enabled && port_q[`SEEP_BIT_LATCH]) && !pin_en) begin
            state_d = pins_s;                                   // [RULE5] [RULE22]
        end
    end

    // registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            port_q   <= `SEEP_PORT_RST;
            unlock_q <= `SEEP_UNLOCK_RST;
            rdata_q  <= 8'h00;
            isa_q    <= 1'b0;
            cs_q     <= 1'b0;
            pins_q   <= '0;
            oe_n_q   <= '1;
            state_q  <= '0;
        end else begin
            port_q   <= port_d;
            unlock_q <= unlock_d;
            rdata_q  <= rdata_d;
            isa_q    <= isa_d;
            cs_q     <= cs_d;
            pins_q   <= pins_d;
            oe_n_q   <= oe_n_d;
            state_q  <= state_d;
        end
    end

    assign rdata_o      = rdata_q;
    assign eeprom_cs_o  = cs_q;
    assign pins_o       = pins_q;
    assign pins_oe_n_o  = oe_n_q;
    assign pins_state_o = state_q;
    assign no_mcs16_o   = port_q[`SEEP_BIT_NOMCS16];            // [RULE8]

    // assertions
    cs_follow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE1]
        ##1 eeprom_cs_o == $past(isa_q && port_q[`SEEP_BIT_CS]))
        else $error("chip select does not follow bit 0");
    clk_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE2]
        !pin_en |=> !pins_o.video)
        else $error("serial clock driven while pins not enabled");
    data_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE3]
        (pin_en && port_q[`SEEP_BIT_WDATA]) |=> pins_o.sync)
        else $error("write line not driven from bit 3");
    pin_dir_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE4]
        pin_en |=> pins_oe_n_o == 2'b00)
        else $error("pins not driven when enabled");
    latch_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE5]
        (enabled && port_q[`SEEP_BIT_LATCH]) |=> $stable(pins_state_o))
        else $error("latched input state changed");
    ret_gate_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE6]
        (rd_i && addr_i == `SEEP_ADDR_PORT && !port_q[`SEEP_BIT_RDEN]) |=> !rdata_o[7])
        else $error("data returned with path disabled");
    rdata_bit_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE7]
        (rd_i && addr_i == `SEEP_ADDR_PORT && enabled && port_q[`SEEP_BIT_RDEN])
        |=> rdata_o[7] == $past(do_s))
        else $error("bit 7 does not show eeprom output");
    isa_only_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE9]
        !isa_q |=> !eeprom_cs_o && pins_oe_n_o == 2'b11)
        else $error("port active without isa strap");
    release_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE22]
        $fell(pin_en) |=> pins_oe_n_o == 2'b11 && pins_o == 2'b00)
        else $error("pins not released");

    // register file and pin copies, one cycle after the cause
    // a port write while locked leaves the register alone
    lock_guard_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE19]
        (wr_i && addr_i == `SEEP_ADDR_PORT && !unlocked)
        |=> port_q == $past(port_q))
        else $error("port written while locked");
    // bit 6 is stored as written, software keeps it
    mcs16_keep_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE8]
        (wr_i && addr_i == `SEEP_ADDR_PORT && unlocked)
        |=> no_mcs16_o == $past(wdata_i[`SEEP_BIT_NOMCS16]))
        else $error("bit 6 not stored");
    // read data stand only in the cycle after a read strobe
    rdata_idle_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE7]
        !rd_i
        |=> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    // without latch and pins, internal state tracks the pads
    state_track_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE5] [RULE22]
        (!(enabled && port_q[`SEEP_BIT_LATCH]) && !pin_en)
        |=> pins_state_o == $past(pins_s))
        else $error("input state does not follow pads");
    // borrowed clock pin copies bit 2
    clk_copy_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE2]
        pin_en
        |=> pins_o.video == $past(port_q[`SEEP_BIT_CLK]))
        else $error("serial clock differs from bit 2");
    // borrowed data pin copies bit 3
    data_copy_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE3]
        pin_en
        |=> pins_o.sync == $past(port_q[`SEEP_BIT_WDATA]))
        else $error("write line differs from bit 3");
    // data pin stays quiet while pins are not borrowed
    data_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE3]
        !pin_en
        |=> !pins_o.sync)
        else $error("write line driven while pins not enabled");
    // unlock register reads back what was written
    unlock_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE19]
        (rd_i && addr_i == `SEEP_ADDR_UNLOCK)
        |=> rdata_o == $past(unlock_q))
        else $error("unlock register read wrong");
    // status shows the synchronised pad levels
    status_read_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [RULE22]
        (rd_i && addr_i == `SEEP_ADDR_STATUS)
        |=> rdata_o == {6'h00, $past(pins_s)})
        else $error("status read wrong");
    cv_enable: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(pin_en));
    cv_clock: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(pins_o.video));
    cv_readbit: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        rd_i && addr_i == `SEEP_ADDR_PORT && bit_in);
    // latch held with pins released, and the release itself
    cv_latch: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        enabled && port_q[`SEEP_BIT_LATCH] && !pin_en);
    cv_release: cover property (@(posedge clock_i) disable iff (!rst_n_i) $fell(pin_en));
endmodule : seep_port

// ---- seep_defs.svh ----
`ifndef SEEP_DEFS_SVH
`define SEEP_DEFS_SVH
// register indices on the plain register port
`define SEEP_ADDR_W          4
`define SEEP_ADDR_PORT       4'h8
`define SEEP_ADDR_UNLOCK     4'h6
`define SEEP_ADDR_STATUS     4'h9
// port register bit positions
`define SEEP_BIT_CS          0
`define SEEP_BIT_RDEN        1
`define SEEP_BIT_CLK         2
`define SEEP_BIT_WDATA       3
`define SEEP_BIT_PINEN       4
`define SEEP_BIT_LATCH       5
`define SEEP_BIT_NOMCS16     6
`define SEEP_BIT_RDATA       7
// reset values and unlock key
`define SEEP_PORT_RST        8'h00
`define SEEP_UNLOCK_RST      8'h00
`define SEEP_UNLOCK_KEY      8'h12
`endif

// ---- seep_pkg.sv ----
package seep_pkg;
    // pin view of one borrowed sync/video pin pair
    typedef struct packed {
        logic sync;
        logic video;
    } seep_pins_s;
endpackage : seep_pkg

// ---- seep_sync.sv ----
// two-flop synchroniser for asynchronous pin levels
module seep_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_i,  // system clock
    input  wire logic         rst_n_i,  // sync reset, active low
    input  wire logic [W-1:0] d_i,      // asynchronous level
    output logic      [W-1:0] q_o       // synchronised level
);
    logic [W-1:0] s1_q, s1_d;
    logic [W-1:0] s2_q, s2_d;

    // next values: first stage read only by the second
    always_comb begin
        s1_d = d_i;
        s2_d = s1_q;
    end

    // registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign q_o = s2_q;
endmodule : seep_sync

// ---- seep_eeprom_model.sv ----
// three-wire serial eeprom: 64 words of 16 bits, msb first
module seep_eeprom_model (
    input  wire logic cs_i,       // chip select
    input  wire logic sk_i,       // serial clock
    input  wire logic di_i,       // serial data in
    output logic      do_o        // serial data out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [64];
    logic [24:0] sh;
    logic [15:0] out;
    logic        wen = 1'b0;
    logic        rdg;
    int          n;
    // the line idles low until the first frame ends
    initial begin
        do_o = 1'b0;
        rdg = 1'b0;
    end
    // leading zeros are idle clocks; counting starts at the start bit
    always @(posedge sk_i or negedge cs_i) begin
        if (!cs_i) begin
            n = 0;
            rdg = 1'b0;
            do_o = ~do_o; // a released line inverts the last value it showed
        end else if (n > 0 || di_i) begin
            sh = {sh[23:0], di_i};
            n = n + 1;
            if (rdg) begin
                do_o = out[15];
                out = out << 1;
            end
            if (n == 9 && sh[7:6] == 2'b10) begin
                out = mem[sh[5:0]];
                rdg = 1'b1;
            end
            if (n == 9 && sh[7:6] == 2'b00)
                wen = (sh[5:4] == 2'b11);
            if (n == 25 && sh[23:22] == 2'b01 && wen)
                mem[sh[21:16]] = sh[15:0];
        end
    end
endmodule : seep_eeprom_model

// ---- serial_eeprom_bitbang_port_test.sv ----
`include "seep_defs.svh"
module serial_eeprom_bitbang_port_test import seep_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock_i = 1'b0, rst_n_i = 1'b0, isa = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, got;
    logic       do_w, cs, nomcs, keep6;
    seep_pins_s ext = 2'b00, pad, pins_o, oe_n, state, old;
    int         bad_count = 0, n_checks = 0;
    // 250 MHz clock
    always #2 clock_i = ~clock_i;
    // pad level: the device drives while its enable is low
    assign pad = {oe_n.sync ? ext.sync : pins_o.sync, oe_n.video ? ext.video : pins_o.video};
    seep_port uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .isa_strap_i(isa), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pins_i(pad), .pins_o(pins_o),
        .pins_oe_n_o(oe_n), .eeprom_do_i(do_w), .eeprom_cs_o(cs), .pins_state_o(state),
        .no_mcs16_o(nomcs));
    seep_eeprom_model mdl (.cs_i(cs), .sk_i(pad.video), .di_i(pad.sync), .do_o(do_w));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // one strobe cycle; read data taken in the cycle after
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clock_i);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 got = rdata;
    endtask : bus
    // port word: bit 6 as kept, latch and both enables alike
    function automatic logic [7:0] port_word(input logic c, input logic k, input logic d,
                                             input logic en);
        return {1'b0, keep6, en, en, d, k, en, c};
    endfunction : port_word
    // port write, strobe to strobe half of the 160 ns link period
    task automatic pw(input logic c, input logic k, input logic d, input logic en);
        bus(1'b1, `SEEP_ADDR_PORT, port_word(c, k, d, en));
        repeat (18) @(posedge clock_i);
    endtask : pw
    task automatic shift(input logic [25:0] v, input int nb);
        for (int i = nb - 1; i >= 0; i--) begin
            pw(1'b1, 1'b0, v[i], 1'b1);
            pw(1'b1, 1'b1, v[i], 1'b1);
            chk(pins_o.video, 1'b1);
            chk(pins_o.sync, v[i]);
            chk(cs, 1'b1);
            pw(1'b1, 1'b0, v[i], 1'b1);
        end
    endtask : shift
    task automatic frame(input logic [25:0] v, input int nb);
        pw(1'b1, 1'b0, 1'b0, 1'b1);
        shift(v, nb);
        pw(1'b0, 1'b0, 1'b0, 1'b1);
    endtask : frame
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // watchdog: the run needs about 82 us, allow over twice that
    initial begin
        #200000;
        bad_count++;
        end_sim();
    end
    initial begin
        logic [15:0] w, d;
        logic [5:0]  a;
        void'($urandom(12137));
        keep6 = 1'($urandom);
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        bus(1'b0, `SEEP_ADDR_PORT, 8'h00);
        chk(got, `SEEP_PORT_RST);
        chk(oe_n, 2'b11);
        bus(1'b1, `SEEP_ADDR_PORT, 8'h01);
        bus(1'b0, `SEEP_ADDR_PORT, 8'h00);
        chk(got, 8'h00);
        isa <= 1'b0;
        bus(1'b1, `SEEP_ADDR_UNLOCK, `SEEP_UNLOCK_KEY);
        bus(1'b0, `SEEP_ADDR_UNLOCK, 8'h00);
        chk(got, `SEEP_UNLOCK_KEY);
        pw(1'b1, 1'b0, 1'b0, 1'b1);
        chk(cs, 1'b0);
        chk(oe_n, 2'b11);
        isa <= 1'b1;
        $display("test lock and strap done");
        pw(1'b0, 1'b0, 1'b0, 1'b0);
        chk(nomcs, keep6);
        ext <= 2'($urandom);
        repeat (20) @(posedge clock_i);
        chk(state, ext);
        old = ext;
        pw(1'b0, 1'b0, 1'b0, 1'b1);
        chk(oe_n, 2'b00);
        bus(1'b0, `SEEP_ADDR_PORT, 8'h00);
        chk(got & 8'h7f, port_word(1'b0, 1'b0, 1'b0, 1'b1));
        ext <= ~ext;
        repeat (20) @(posedge clock_i);
        chk(state, old);
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
            d = 16'($urandom);
            frame(26'b01001100000, 11);
            frame({4'b0101, a, d}, 26);
            repeat (2500) @(posedge clock_i);
            frame(26'b01000000000, 11);
            pw(1'b1, 1'b0, 1'b0, 1'b1);
            // idle zero, start bit and read opcode, then the address
            shift({16'h0, 4'b0110, a}, 10);
            for (int b = 0; b < 16; b++) begin
                pw(1'b1, 1'b1, 1'b0, 1'b1);
                pw(1'b1, 1'b0, 1'b0, 1'b1);
                bus(1'b0, `SEEP_ADDR_PORT, 8'h00);
                w = {w[14:0], got[7]};
            end
            pw(1'b0, 1'b0, 1'b0, 1'b1);
            chk(w[15:8], d[15:8]);
            chk(w[7:0], d[7:0]);
            $display("test word %0d done", i);
        end
        bus(1'b1, `SEEP_ADDR_PORT, {1'b0, keep6, 6'h20});
        repeat (3) @(posedge clock_i);
        chk(oe_n, 2'b11);
        chk(state, old);
        pw(1'b0, 1'b0, 1'b0, 1'b0);
        chk(state, ext);
        bus(1'b0, `SEEP_ADDR_STATUS, 8'h00);
        chk(got, {6'h00, ext});
        bus(1'b0, 4'hf, 8'h00);
        chk(got, 8'h00);
        bus(1'b1, `SEEP_ADDR_UNLOCK, 8'h00);
        $display("test leave done");
        end_sim();
    end
endmodule : serial_eeprom_bitbang_port_test
